// ---- common/efbo_consts.vh ----
// Constants for the embedded flash block operation controller
`ifndef EFBO_CONSTS_VH
`define EFBO_CONSTS_VH
// Status codes
`define EFBO_ST_OK          2'h0
`define EFBO_ST_PROT        2'h1
`define EFBO_ST_UNCOR       2'h2
`define EFBO_ST_LOSS        2'h3
// Address fields: sector and page form one page index
`define EFBO_PG_HI          17
`define EFBO_PG_LO          7
`define EFBO_BLK_HI         6
`define EFBO_BLK_LO         4
`define EFBO_WRD_HI         6
`define EFBO_WRD_LO         2
`define EFBO_RA_LO          4
// Page status word layout
`define EFBO_PS_RSV         4'h0
`define EFBO_PS_OVT         3
`define EFBO_PS_RDP         2
`define EFBO_PS_WRP         1
`define EFBO_PS_OWP         0
// Reset values
`define EFBO_PG_RST         11'h000
`define EFBO_RA_RST         14'h0000
// Timing
`define EFBO_CLK_NS         4
`define EFBO_PROG_NS        8000000
// Program time in clocks, sized to the 24-bit counter
`define EFBO_PROG_CYC       24'h1E8480
`define EFBO_BLKSW_CYC      24'h000004
`define EFBO_BLKSW_PIPE_CYC 24'h000005
`define EFBO_RD_CYC         24'h000002
`define EFBO_RD_PIPE_CYC    24'h000003
`define EFBO_INIT_CYC       24'h000008
`define EFBO_THRESH         24'h0003E8
`endif

// ---- src/efbo_core.v ----
// Embedded flash block operation controller: user port, buffers, array model
`timescale 1ns/1ps
`include "efbo_consts.vh"
module efbo_core #(
  parameter [23:0] PROG_CYCLES = `EFBO_PROG_CYC,
  parameter [23:0] WR_THRESH   = `EFBO_THRESH,
  parameter [23:0] INIT_CYCLES = `EFBO_INIT_CYC
) (
  input  wire        ref_clk,
  input  wire        reset_n,
  input  wire        fb_reset_req,
  input  wire        read_req,
  input  wire        write_req,
  input  wire        erase_request,
  input  wire        program_req,
  input  wire        clear_protection_request,
  input  wire        drop_buffer_request,
  input  wire [17:0] addr,
  input  wire [31:0] wdata,
  input  wire [1:0]  word_size_select,
  input  wire        pipe_select,
  input  wire        read_ahead_select,
  input  wire        protection_info_read,
  input  wire        page_redirect,
  input  wire        protect_on_program,
  input  wire        buffer_loss_guard,
  input  wire [1:0]  ecc_inject,
  input  wire        tp_set,
  input  wire [10:0] tp_page,
  input  wire        tp_read_prot,
  input  wire        tp_write_prot,
  output reg         busy_reg,
  output reg  [31:0] rdata_reg,
  output reg  [1:0]  status_reg
);

  localparam [2:0] S_IDLE  = 3'h0;
  localparam [2:0] S_INIT  = 3'h1;
  localparam [2:0] S_LOAD  = 3'h2;
  localparam [2:0] S_BLKSW = 3'h3;
  localparam [2:0] S_PROG  = 3'h4;
  localparam [2:0] S_ERASE = 3'h5;
  localparam [2:0] S_READ  = 3'h6;
  localparam [2:0] S_HOLD  = 3'h7;
  localparam       NPG     = 2048;
  localparam       NWRD    = 65536;

  // Array content has no reset; only the metadata does
  reg [31:0] flash_mem [0:NWRD-1];
  reg [31:0] pb_data   [0:31];
  reg        owp_mem   [0:NPG-1];
  reg        rdp_mem   [0:NPG-1];
  reg        wrp_mem   [0:NPG-1];
  reg [23:0] wcnt_mem  [0:NPG-1];

  reg [2:0]  state_reg;
  reg [23:0] cnt_reg;
  reg [5:0]  idx_reg;
  reg        pb_valid_reg;
  reg        pb_mod_reg;
  reg [10:0] pb_page_reg;
  reg [2:0]  blk_reg;
  reg        blk_valid_reg;
  reg        ra_valid_reg;
  reg [13:0] ra_next_reg;
  reg [10:0] op_pg_reg;
  reg [4:0]  op_wi_reg;
  reg [31:0] op_wd_reg;
  reg [31:0] op_mask_reg;
  reg [4:0]  op_sh_reg;
  reg        op_wr_reg;
  reg        op_prot_reg;
  reg [1:0]  op_st_reg;
  reg [31:0] op_data_reg;
  reg        pb_we;
  reg [4:0]  pb_wa;
  reg [31:0] pb_wd;
  reg        fm_we;
  reg [31:0] fm_wd;
  integer    i;

  function [31:0] efbo_merge;
    input [31:0] old;
    input [31:0] wd;
    input [31:0] mask;
    input [4:0]  s;
    begin
      efbo_merge = (old & ~(mask << s)) | ((wd << s) & (mask << s));
    end
  endfunction

  wire [10:0] a_pg     = addr[`EFBO_PG_HI:`EFBO_PG_LO];
  wire [4:0]  a_wi     = addr[`EFBO_WRD_HI:`EFBO_WRD_LO];
  wire [2:0]  a_blk    = addr[`EFBO_BLK_HI:`EFBO_BLK_LO];
  wire [13:0] a_ra     = addr[`EFBO_PG_HI:`EFBO_RA_LO];
  wire [13:0] nxt_blk  = a_ra + 14'h0001;
  wire        pb_hit   = pb_valid_reg && (pb_page_reg == a_pg);
  wire        a_owp    = owp_mem[a_pg];
  wire [23:0] a_wcnt   = wcnt_mem[a_pg];
  wire        loss_blk = buffer_loss_guard && pb_mod_reg && !pb_hit;
  // Width select: byte and halfword lanes sit at the low end of the data pins
  wire [4:0]  sh       = (word_size_select == 2'h0) ? {addr[1:0], 3'h0} :
                         (word_size_select == 2'h1) ? {addr[1], 4'h0} : 5'h00;
  wire [31:0] lane_mask = (word_size_select == 2'h0) ? 32'h000000FF :
                          (word_size_select == 2'h1) ? 32'h0000FFFF : 32'hFFFFFFFF;
  wire [31:0] src_word = pb_hit ? pb_data[a_wi] : flash_mem[{a_pg, a_wi}];
  wire [31:0] pstat    = {a_wcnt, `EFBO_PS_RSV, (a_wcnt > WR_THRESH), rdp_mem[a_pg],
                          wrp_mem[a_pg], a_owp};
  wire [31:0] rd_fmt   = protection_info_read ? pstat : (src_word >> sh);
  wire [1:0]  ecc_st   = ecc_inject[1] ? `EFBO_ST_UNCOR :
                         ecc_inject[0] ? `EFBO_ST_PROT : `EFBO_ST_OK;
  // Outcome of a program or erase that passed its checks
  wire [1:0]  post_st  = (a_wcnt >= WR_THRESH) ? `EFBO_ST_LOSS :
                         ecc_inject[1] ? `EFBO_ST_UNCOR : `EFBO_ST_OK;
  // Redirect is only looked at in these two checks
  wire        prog_err = a_owp || loss_blk || !pb_valid_reg ||
                         (!page_redirect && !pb_hit) || (pb_hit && !pb_mod_reg);
  wire        er_err   = a_owp || loss_blk ||
                         (!page_redirect && !pb_hit && pb_mod_reg);
  wire        rd_ahead = read_ahead_select && ra_valid_reg && !protection_info_read &&
                         (a_ra == ra_next_reg);

  // Fixed priority; busy low is the only acceptance window
  wire go     = !busy_reg;
  wire hi_rd  = fb_reset_req | read_req;
  wire hi_wr  = hi_rd | write_req;
  wire hi_er  = hi_wr | erase_request;
  wire hi_pg  = hi_er | program_req;
  wire hi_un  = hi_pg | clear_protection_request;
  wire sel_rst = go && fb_reset_req;
  wire sel_rd  = go && !fb_reset_req && read_req;
  wire sel_wr  = go && !hi_rd && write_req;
  wire sel_er  = go && !hi_wr && erase_request;
  wire sel_pg  = go && !hi_er && program_req;
  wire sel_un  = go && !hi_pg && clear_protection_request;
  wire sel_dc  = go && !hi_un && drop_buffer_request;
  wire wr_ok   = sel_wr && !a_owp && !loss_blk;
  wire wr_hit  = wr_ok && pb_hit && blk_valid_reg && (blk_reg == a_blk);

  // Write ports of the buffer and the array
  always @* begin
    pb_we = 1'b0;
    pb_wa = a_wi;
    pb_wd = efbo_merge(pb_data[a_wi], wdata, lane_mask, sh);
    fm_we = 1'b0;
    fm_wd = pb_data[idx_reg[4:0]];
    case (state_reg)
      S_IDLE: begin
        pb_we = wr_hit;
      end
      S_LOAD: begin
        if (!idx_reg[5]) begin
          pb_we = 1'b1;
          pb_wa = idx_reg[4:0];
          pb_wd = flash_mem[{op_pg_reg, idx_reg[4:0]}];
        end else begin
          pb_we = op_wr_reg;
          pb_wa = op_wi_reg;
          pb_wd = efbo_merge(pb_data[op_wi_reg], op_wd_reg, op_mask_reg, op_sh_reg);
        end
      end
      S_BLKSW: begin
        pb_we = (cnt_reg == 24'h000001);
        pb_wa = op_wi_reg;
        pb_wd = efbo_merge(pb_data[op_wi_reg], op_wd_reg, op_mask_reg, op_sh_reg);
      end
      S_PROG: begin
        fm_we = !idx_reg[5];
      end
      S_ERASE: begin
        fm_we = !idx_reg[5];
        fm_wd = 32'h00000000;
      end
      default: begin
        pb_we = 1'b0;
      end
    endcase
  end

  always @(posedge ref_clk) begin
    if (pb_we) begin
      pb_data[pb_wa] <= pb_wd;
    end
    if (fm_we) begin
      flash_mem[{op_pg_reg, idx_reg[4:0]}] <= fm_wd;
    end
  end

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg     <= S_INIT;
      cnt_reg       <= INIT_CYCLES;
      idx_reg       <= 6'h00;
      busy_reg      <= 1'b1;
      rdata_reg     <= 32'h00000000;
      status_reg    <= `EFBO_ST_OK;
      pb_valid_reg  <= 1'b0;
      pb_mod_reg    <= 1'b0;
      pb_page_reg   <= `EFBO_PG_RST;
      blk_reg       <= 3'h0;
      blk_valid_reg <= 1'b0;
      ra_valid_reg  <= 1'b0;
      ra_next_reg   <= `EFBO_RA_RST;
      op_pg_reg     <= `EFBO_PG_RST;
      op_wi_reg     <= 5'h00;
      op_wd_reg     <= 32'h00000000;
      op_mask_reg   <= 32'h00000000;
      op_sh_reg     <= 5'h00;
      op_wr_reg     <= 1'b0;
      op_prot_reg   <= 1'b0;
      op_st_reg     <= `EFBO_ST_OK;
      op_data_reg   <= 32'h00000000;
      for (i = 0; i < NPG; i = i + 1) begin
        owp_mem[i]  <= 1'b0;
        rdp_mem[i]  <= 1'b0;
        wrp_mem[i]  <= 1'b0;
        wcnt_mem[i] <= 24'h000000;
      end
    end else begin
      // Test port only; user operations only report these bits in the page status word
      if (tp_set) begin
        rdp_mem[tp_page] <= tp_read_prot;
        wrp_mem[tp_page] <= tp_write_prot;
      end
      case (state_reg)
        S_IDLE: begin
          op_wi_reg   <= a_wi;
          op_wd_reg   <= wdata;
          op_mask_reg <= lane_mask;
          op_sh_reg   <= sh;
          op_pg_reg   <= a_pg;
          op_prot_reg <= protect_on_program;
          idx_reg     <= 6'h00;
          if (sel_rst) begin
            pb_valid_reg  <= 1'b0;
            pb_mod_reg    <= 1'b0;
            blk_valid_reg <= 1'b0;
            ra_valid_reg  <= 1'b0;
            // Without this the hold state would replay a stale result
            op_st_reg     <= `EFBO_ST_OK;
            cnt_reg       <= 24'h000001;
            state_reg     <= S_HOLD;
            busy_reg      <= 1'b1;
          end else if (sel_rd) begin
            ra_valid_reg <= 1'b1;
            ra_next_reg  <= nxt_blk;
            if (rd_ahead) begin
              rdata_reg  <= rd_fmt;
              status_reg <= ecc_st;
            end else begin
              op_data_reg <= rd_fmt;
              op_st_reg   <= ecc_st;
              cnt_reg     <= pipe_select ? `EFBO_RD_PIPE_CYC : `EFBO_RD_CYC;
              state_reg   <= S_READ;
              busy_reg    <= 1'b1;
            end
          end else if (sel_wr) begin
            if (a_owp) begin
              status_reg <= `EFBO_ST_PROT;
            end else if (loss_blk) begin
              status_reg <= `EFBO_ST_LOSS;
            end else if (wr_hit) begin
              pb_mod_reg <= 1'b1;
              status_reg <= `EFBO_ST_OK;
            end else if (pb_hit) begin
              cnt_reg   <= pipe_select ? `EFBO_BLKSW_PIPE_CYC : `EFBO_BLKSW_CYC;
              state_reg <= S_BLKSW;
              busy_reg  <= 1'b1;
            end else begin
              // An unguarded modified buffer is dropped here
              pb_valid_reg  <= 1'b0;
              pb_mod_reg    <= 1'b0;
              blk_valid_reg <= 1'b0;
              op_wr_reg     <= 1'b1;
              op_st_reg     <= `EFBO_ST_OK;
              state_reg     <= S_LOAD;
              busy_reg      <= 1'b1;
            end
          end else if (sel_er) begin
            if (er_err) begin
              status_reg <= `EFBO_ST_PROT;
            end else begin
              op_st_reg <= post_st;
              cnt_reg   <= PROG_CYCLES;
              state_reg <= S_ERASE;
              busy_reg  <= 1'b1;
            end
          end else if (sel_pg) begin
            if (prog_err) begin
              status_reg <= `EFBO_ST_PROT;
            end else begin
              op_st_reg <= post_st;
              cnt_reg   <= PROG_CYCLES;
              state_reg <= S_PROG;
              busy_reg  <= 1'b1;
            end
          end else if (sel_un) begin
            if (loss_blk) begin
              status_reg <= `EFBO_ST_LOSS;
            end else begin
              owp_mem[a_pg] <= 1'b0;
              op_wr_reg     <= 1'b0;
              op_st_reg     <= ecc_st;
              busy_reg      <= 1'b1;
              cnt_reg       <= 24'h000001;
              state_reg     <= pb_hit ? S_HOLD : S_LOAD;
              if (!pb_hit) begin
                pb_valid_reg  <= 1'b0;
                pb_mod_reg    <= 1'b0;
                blk_valid_reg <= 1'b0;
              end
            end
          end else if (sel_dc) begin
            pb_mod_reg <= 1'b0;
            op_st_reg  <= `EFBO_ST_OK;
            cnt_reg    <= 24'h000001;
            state_reg  <= S_HOLD;
            busy_reg   <= 1'b1;
          end
        end
        S_INIT, S_HOLD, S_READ: begin
          cnt_reg <= cnt_reg - 24'h000001;
          if (cnt_reg == 24'h000001) begin
            if (state_reg == S_READ) begin
              rdata_reg <= op_data_reg;
            end
            if (state_reg != S_INIT) begin
              status_reg <= op_st_reg;
            end
            state_reg <= S_IDLE;
            busy_reg  <= 1'b0;
          end
        end
        S_LOAD: begin
          if (!idx_reg[5]) begin
            idx_reg <= idx_reg + 6'h01;
          end else begin
            pb_valid_reg  <= 1'b1;
            pb_page_reg   <= op_pg_reg;
            pb_mod_reg    <= op_wr_reg;
            blk_reg       <= op_wi_reg[4:2];
            blk_valid_reg <= 1'b1;
            status_reg    <= op_st_reg;
            state_reg     <= S_IDLE;
            busy_reg      <= 1'b0;
          end
        end
        S_BLKSW: begin
          cnt_reg <= cnt_reg - 24'h000001;
          if (cnt_reg == 24'h000001) begin
            blk_reg    <= op_wi_reg[4:2];
            pb_mod_reg <= 1'b1;
            status_reg <= `EFBO_ST_OK;
            state_reg  <= S_IDLE;
            busy_reg   <= 1'b0;
          end
        end
        default: begin
          // Program and erase: array written in the first words, busy for the full time
          if (!idx_reg[5]) begin
            idx_reg <= idx_reg + 6'h01;
          end
          cnt_reg <= cnt_reg - 24'h000001;
          if (cnt_reg == 24'h000001) begin
            wcnt_mem[op_pg_reg] <= wcnt_mem[op_pg_reg] + 24'h000001;
            if (state_reg == S_PROG) begin
              owp_mem[op_pg_reg] <= op_prot_reg;
              pb_mod_reg         <= 1'b0;
            end else if (pb_valid_reg && pb_page_reg == op_pg_reg) begin
              // Buffer copy of an erased page would be stale
              pb_valid_reg  <= 1'b0;
              pb_mod_reg    <= 1'b0;
              blk_valid_reg <= 1'b0;
            end
            status_reg <= op_st_reg;
            state_reg  <= S_IDLE;
            busy_reg   <= 1'b0;
          end
        end
      endcase
    end
  end

endmodule

// ---- testbench/efbo_user_model.sv ----
// Fabric requester model: one-cycle requests issued only while busy is low
`timescale 1ns/1ps
module efbo_user_model (
  input  wire       ref_clk,
  input  wire       busy_reg,
  input  wire       go,
  input  wire [6:0] req_in,
  output reg  [6:0] req_out,
  output reg        sent
);
  initial req_out = 7'h00;
  initial sent = 1'b0;
  // Request lasts one cycle; sent guards against a second issue before go drops
  always @(posedge ref_clk) begin
    sent <= 1'b0;
    if (|req_out) begin
      req_out <= 7'h00;
      sent    <= 1'b1;
    end else if (go && !sent && !busy_reg) begin
      req_out <= req_in;
    end
  end
endmodule

// ---- testbench/efbo_core_properties.sv ----
// Concurrent checks on the flash block user port
`timescale 1ns/1ps
module efbo_core_props #(
  parameter [23:0] PROG_CYCLES = 24'h000028
) (
  input wire        ref_clk,
  input wire        reset_n,
  input wire        fb_reset_req,
  input wire        read_req,
  input wire        write_req,
  input wire        erase_request,
  input wire        program_req,
  input wire        clear_protection_request,
  input wire        drop_buffer_request,
  input wire        pipe_select,
  input wire        read_ahead_select,
  input wire        protection_info_read,
  input wire        busy_reg,
  input wire [31:0] rdata_reg,
  input wire [1:0]  status_reg
);
  wire any_req = fb_reset_req | read_req | write_req | erase_request | program_req
    | clear_protection_request | drop_buffer_request;
  wire take = !busy_reg && any_req;
  wire rd_take = !busy_reg && read_req && !fb_reset_req;
  wire rd_norm = rd_take && !read_ahead_select;
  wire pg_take = take && program_req && !(fb_reset_req | read_req | write_req | erase_request);
  reg        ps_pend_reg;
  reg [23:0] run_reg;
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Length of the current busy stretch, so long waits need no repetition
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ps_pend_reg <= 1'b0;
      run_reg     <= 24'h000000;
    end else begin
      if (rd_norm && protection_info_read)
        ps_pend_reg <= 1'b1;
      else if ($fell(busy_reg))
        ps_pend_reg <= 1'b0;
      run_reg <= busy_reg ? run_reg + 24'h000001 : 24'h000000;
    end
  end
  init_busy_a: assert property ($rose(reset_n) |-> busy_reg [*4])
    else $error("busy low during initialization");
  idle_quiet_a: assert property (!busy_reg && !any_req |=> !busy_reg)
    else $error("busy rose without a request");
  read_wait_a: assert property (rd_norm && !pipe_select |=> busy_reg [*2] ##1 !busy_reg)
    else $error("read busy length wrong");
  status_hold_a: assert property ($changed(status_reg) |-> $fell(busy_reg) || $past(take))
    else $error("status changed with no operation");
  rdata_hold_a: assert property ($changed(rdata_reg) |-> $fell(busy_reg) || $past(rd_take))
    else $error("read data changed with no read");
  busy_limit_a: assert property (run_reg <= PROG_CYCLES)
    else $error("busy longer than program time");
  ps_reserved_a: assert property (ps_pend_reg && $fell(busy_reg) |-> rdata_reg[7:4] == 4'h0)
    else $error("page status reserved bits set");
  prog_outcome_a: assert property (pg_take |-> ##2 (busy_reg || status_reg == 2'h1))
    else $error("program neither ran nor refused");
  cover property (rd_norm && protection_info_read);
  cover property (pg_take ##2 busy_reg);
  cover property (rd_take && write_req);
endmodule
bind efbo_core efbo_core_props #(.PROG_CYCLES(PROG_CYCLES)) i_efbo_core_props (
  .ref_clk(ref_clk), .reset_n(reset_n), .fb_reset_req(fb_reset_req), .read_req(read_req),
  .write_req(write_req), .erase_request(erase_request), .program_req(program_req),
  .clear_protection_request(clear_protection_request), .drop_buffer_request(drop_buffer_request),
  .pipe_select(pipe_select), .read_ahead_select(read_ahead_select),
  .protection_info_read(protection_info_read), .busy_reg(busy_reg), .rdata_reg(rdata_reg),
  .status_reg(status_reg));

// ---- testbench/tb_top.sv ----
// Self-checking bench for the flash block operation controller
`timescale 1ns/1ps
module tb_top;
  localparam [6:0]  RS = 7'h01, RD = 7'h02, WR = 7'h04, ER = 7'h08, PG = 7'h10, UP = 7'h20, DB = 7'h40;
  localparam [7:0]  PC = 8'h28, NA = 8'hFF;
  localparam [31:0] Z = 32'h0;
  reg         ref_clk, reset_n, go, pipe_sel, ps_rd, redir, prot, guard, tp_set, tp_rp, tp_wp, ra_sel;
  reg  [17:0] addr;
  reg  [31:0] wdata, d0, d1, w0;
  reg  [1:0]  wsz, ecc;
  reg  [6:0]  req_in;
  reg  [7:0]  n, busy_n;
  reg  [42:0] nt;
  reg  [42:0] notes[$];
  wire [6:0]  req;
  wire        sent, busy_reg;
  wire [31:0] rdata_reg;
  wire [1:0]  status_reg;
  integer     seed, fail_count, total_checks, i;
  event       res_ev;
  efbo_core #(.PROG_CYCLES(24'h000028), .WR_THRESH(24'h000002), .INIT_CYCLES(24'h000008)) i_efbo_core (
    .ref_clk(ref_clk), .reset_n(reset_n), .fb_reset_req(req[0]), .read_req(req[1]),
    .write_req(req[2]), .erase_request(req[3]), .program_req(req[4]),
    .clear_protection_request(req[5]), .drop_buffer_request(req[6]), .addr(addr), .wdata(wdata),
    .word_size_select(wsz), .pipe_select(pipe_sel), .read_ahead_select(ra_sel),
    .protection_info_read(ps_rd), .page_redirect(redir), .protect_on_program(prot),
    .buffer_loss_guard(guard), .ecc_inject(ecc), .tp_set(tp_set), .tp_page(11'h006),
    .tp_read_prot(tp_rp), .tp_write_prot(tp_wp), .busy_reg(busy_reg), .rdata_reg(rdata_reg),
    .status_reg(status_reg));
  efbo_user_model i_efbo_user_model (.ref_clk(ref_clk), .busy_reg(busy_reg), .go(go),
    .req_in(req_in), .req_out(req), .sent(sent));
  always #2 ref_clk = ~ref_clk;
  function [17:0] p(input [10:0] pn);
    p = {pn, 7'h00};
  endfunction
  task chk(input string nm, input [31:0] s, input [31:0] e);
    total_checks = total_checks + 1;
    if (s !== e) begin
      fail_count = fail_count + 1;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One operation; busy is counted in cycles, NA skips the check of that count
  task op(input [6:0] rq, input [17:0] a, input [31:0] d, input [1:0] es, input [31:0] ed,
          input cd, input [7:0] en);
    notes.push_back({es, ed, cd, en});
    addr   <= a;
    wdata  <= d;
    req_in <= rq;
    go     <= 1'b1;
    do @(posedge ref_clk); while (sent !== 1'b1);
    go <= 1'b0;
    n = 8'h00;
    // Taken one edge ago, so busy of this operation shows from this edge on
    while (busy_reg === 1'b1 && n < 8'hC8) begin
      n = n + 8'h01;
      @(posedge ref_clk);
    end
    busy_n = n;
    if (n == 8'hC8) fail_count = fail_count + 1;
    -> res_ev;
    // One idle edge keeps go from being lowered and raised in one time step
    @(posedge ref_clk);
  endtask
  always @(res_ev) begin
    nt = notes.pop_front();
    chk("status", {30'h0, status_reg}, {30'h0, nt[42:41]});
    if (nt[8]) chk("rdata", rdata_reg, nt[40:9]);
    if (nt[7:0] != NA) chk("busy", {24'h0, busy_n}, {24'h0, nt[7:0]});
  end
  // Expected run is about 2400 ns; 40000 ns, over fifteen times that, marks a hang
  initial begin
    #40000;
    fail_count = fail_count + 1;
    test_done;
  end
  initial begin
    {ref_clk, reset_n, go, pipe_sel, ps_rd, redir, prot, guard, tp_set, tp_rp, tp_wp, ra_sel} = 12'h000;
    addr = 18'h00000;
    wdata = Z;
    wsz = 2'h2;
    ecc = 2'h0;
    req_in = 7'h00;
    fail_count = 0;
    total_checks = 0;
    seed = 32'h8F1166E1;
    d0 = $random(seed);
    d1 = $random(seed);
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    while (busy_reg !== 1'b0) @(posedge ref_clk);
    op(WR, p(1), d0, 2'h0, Z, 1'b0, 8'h21);
    redir <= 1'b1;
    op(WR, p(1) + 18'h4, d1, 2'h0, Z, 1'b0, 8'h00);
    redir <= 1'b0;
    op(WR, p(1) + 18'h10, d1, 2'h0, Z, 1'b0, 8'h04);
    pipe_sel <= 1'b1;
    op(WR, p(1) + 18'h20, $random(seed), 2'h0, Z, 1'b0, 8'h05);
    op(RD, p(1) + 18'h4, Z, 2'h0, d1, 1'b1, 8'h03);
    pipe_sel <= 1'b0;
    wsz <= 2'h0;
    op(WR, p(1) + 18'h1, 32'h000000AB, 2'h0, Z, 1'b0, NA);
    wsz <= 2'h2;
    w0 = {d0[31:16], 8'hAB, d0[7:0]};
    op(RD | WR, p(1), ~w0, 2'h0, w0, 1'b1, 8'h02);
    op(RD, p(1), Z, 2'h0, w0, 1'b1, 8'h02);
    for (i = 1; i < 3; i = i + 1) begin
      ecc <= i[1:0];
      op(RD, p(1), Z, i[1:0], w0, i == 1, 8'h02);
    end
    ecc <= 2'h0;
    ra_sel <= 1'b1;
    op(RD, p(1) + 18'h10, Z, 2'h0, d1, 1'b1, 8'h00);
    ra_sel <= 1'b0;
    prot <= 1'b1;
    op(PG, p(1), Z, 2'h0, Z, 1'b0, PC);
    prot <= 1'b0;
    ps_rd <= 1'b1;
    op(RD, p(1), Z, 2'h0, 32'h00000101, 1'b1, 8'h02);
    ps_rd <= 1'b0;
    op(WR, p(1), Z, 2'h1, Z, 1'b0, 8'h00);
    op(PG, p(1), Z, 2'h1, Z, 1'b0, 8'h00);
    op(ER, p(1), Z, 2'h1, Z, 1'b0, 8'h00);
    redir <= 1'b1;
    for (i = 0; i < 3; i = i + 1)
      op(PG, p(2), Z, (i == 2) ? 2'h3 : 2'h0, Z, 1'b0, PC);
    ecc <= 2'h2;
    op(PG, p(3), Z, 2'h2, Z, 1'b0, PC);
    ecc <= 2'h0;
    op(PG, p(1), Z, 2'h1, Z, 1'b0, 8'h00);
    redir <= 1'b0;
    op(PG, p(2), Z, 2'h1, Z, 1'b0, 8'h00);
    op(RD, p(2), Z, 2'h0, w0, 1'b1, 8'h02);
    op(WR, p(4), d1, 2'h0, Z, 1'b0, 8'h21);
    guard <= 1'b1;
    op(WR, p(5), Z, 2'h3, Z, 1'b0, 8'h00);
    op(PG, p(5), Z, 2'h1, Z, 1'b0, 8'h00);
    op(ER, p(5), Z, 2'h1, Z, 1'b0, 8'h00);
    op(DB, p(4), Z, 2'h0, Z, 1'b0, 8'h01);
    guard <= 1'b0;
    op(PG, p(4), Z, 2'h1, Z, 1'b0, 8'h00);
    op(ER, p(4), Z, 2'h0, Z, 1'b0, PC);
    op(RD, p(4), Z, 2'h0, Z, 1'b1, 8'h02);
    tp_rp <= 1'b1;
    tp_wp <= 1'b1;
    tp_set <= 1'b1;
    @(posedge ref_clk);
    tp_set <= 1'b0;
    ps_rd <= 1'b1;
    op(RD, p(6), Z, 2'h0, 32'h00000006, 1'b1, 8'h02);
    ps_rd <= 1'b0;
    op(WR, p(6), d0, 2'h0, Z, 1'b0, 8'h21);
    op(PG, p(7), Z, 2'h1, Z, 1'b0, 8'h00);
    op(UP, p(1), Z, 2'h0, Z, 1'b0, 8'h21);
    ecc <= 2'h2;
    ps_rd <= 1'b1;
    op(RD, p(1), Z, 2'h2, 32'h00000100, 1'b1, 8'h02);
    ps_rd <= 1'b0;
    ecc <= 2'h0;
    op(RS, p(1), Z, 2'h0, Z, 1'b0, 8'h01);
    op(PG, p(1), Z, 2'h1, Z, 1'b0, 8'h00);
    repeat (4) @(posedge ref_clk);
    test_done;
  end
endmodule
